// ===== hw/ehp_defines.vh
// Constants for the enhanced host port access block
// Notes on behaviour
// - Nonmultiplexed, select low reaches control register
// - Chip select may act as strobe
// - Ready output always driven with state
// - Autoincrement advances address, readback gives base
// - Byte mode advances only after high byte
// - Memory contention stretches access latency
`ifndef EHP_DEFINES_VH
`define EHP_DEFINES_VH
`define EHP_DW 16
`define EHP_AW 16
`define EHP_SEL_CTRL 2'h0
`define EHP_SEL_DATA_INC 2'h1
`define EHP_SEL_ADDR 2'h2
`define EHP_SEL_DATA 2'h3
`define EHP_CTRL_RST 16'h0000
`define EHP_ADDR_RST 16'h0000
`define EHP_ADDR_ONE 16'h0001
`define EHP_ST_IDLE 2'h0
`define EHP_ST_MEM 2'h1
`define EHP_ST_DONE 2'h2
`define EHP_PIN_W 24
`define EHP_PIN_IDLE 24'h000007
`define EHP_P_CS 0
`define EHP_P_DSA 1
`define EHP_P_DSB 2
`define EHP_P_RW 3
`define EHP_P_SEL_LO 4
`define EHP_P_SEL_HI 5
`define EHP_P_BE_LO 6
`define EHP_P_BE_HI 7
`define EHP_P_DIN_LO 8
`define EHP_P_DIN_HI 23
`define EHP_BE_UP 1
`define EHP_DATA_RST 16'h0000
`define EHP_BE_RST 2'h0
`endif

// ===== hw/ehp_port.v
// Enhanced host port: strobe decode, register access and memory side
`default_nettype none
`include "ehp_defines.vh"
module ehp_port (
    input wire CLK,
    input wire RST,
    input wire CE,
    input wire MUX_MODE,
    input wire HOST_CHIP_SELECT_N,
    input wire HOST_DATA_STROBE_A,
    input wire HOST_DATA_STROBE_B,
    input wire HOST_RW,
    input wire [1:0] ACCESS_SELECT,
    input wire [1:0] HOST_BYTE_ENABLE_N,
    input wire [15:0] HOST_DATA_IN,
    output reg [15:0] HOST_DATA_OUT,
    output wire HOST_DATA_OE,
    output wire HOST_READY_OUT,
    output wire [15:0] CTRL_OUT,
    output reg MEM_REQ,
    output reg MEM_WE,
    output reg [15:0] MEM_ADDR,
    output reg [15:0] MEM_WDATA,
    output reg [1:0] MEM_BE,
    input wire MEM_ACK,
    input wire [15:0] MEM_RDATA
);
    // Two-flop synchronisers for all host pins; MUX_MODE is used unsynchronised
    // Reset to the idle pin levels, so no false strobe edge follows reset
    reg [`EHP_PIN_W-1:0] s1_r;
    reg [`EHP_PIN_W-1:0] s2_r;
    wire [`EHP_PIN_W-1:0] pins = {HOST_DATA_IN, HOST_BYTE_ENABLE_N, ACCESS_SELECT, HOST_RW, HOST_DATA_STROBE_B,
                        HOST_DATA_STROBE_A, HOST_CHIP_SELECT_N};
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            s1_r <= `EHP_PIN_IDLE;
            s2_r <= `EHP_PIN_IDLE;
        end else if (CE) begin
            s1_r <= pins;
            s2_r <= s1_r;
        end
    end
    // Only the second flop is read; the first may still be settling
    wire cs_n = s2_r[`EHP_P_CS];
    wire ds_a = s2_r[`EHP_P_DSA];
    wire ds_b = s2_r[`EHP_P_DSB];
    wire rw = s2_r[`EHP_P_RW];
    wire [1:0] sel = s2_r[`EHP_P_SEL_HI:`EHP_P_SEL_LO];
    wire [1:0] be_n = s2_r[`EHP_P_BE_HI:`EHP_P_BE_LO];
    wire [15:0] din = s2_r[`EHP_P_DIN_HI:`EHP_P_DIN_LO];

    // Active only while select and both strobes are low; a tied strobe leaves chip select in charge
    wire strobe = ~cs_n & ~ds_a & ~ds_b;
    reg strobe_r;

    // Nonmultiplexed: only the low select bit matters, low means control
    function [1:0] eff_sel;
        input mux;
        input [1:0] s;
        begin
            if (mux)
                eff_sel = s;
            else if (!s[0])
                eff_sel = `EHP_SEL_CTRL;
            else
                eff_sel = `EHP_SEL_DATA;
        end
    endfunction

    reg [15:0] ctrl_r;
    reg [15:0] base_r;
    reg [15:0] addr_r;
    reg [1:0] st_r;
    reg [1:0] st_nxt;
    reg [1:0] cur_sel_r;
    reg ready_r;
    reg oe_r;
    wire [1:0] csel = eff_sel(MUX_MODE, sel);
    wire start = strobe & ~strobe_r;

    // Accesses are taken only from idle; a strobe held over is refused
    wire take = start & (st_r == `EHP_ST_IDLE);
    wire take_ctrl = take & (csel == `EHP_SEL_CTRL);
    wire take_addr = take & (csel == `EHP_SEL_ADDR);
    wire take_mem = take & ~take_ctrl & ~take_addr;
    wire mem_done = (st_r == `EHP_ST_MEM) & MEM_ACK;
    wire is_inc = (cur_sel_r == `EHP_SEL_DATA_INC);
    // Byte-wide access: advance only once the high byte is done
    wire step = is_inc & (be_n[`EHP_BE_UP] == 1'b0);

    // Address after a finished memory access; wraps at the top
    function [15:0] addr_after;
        input [15:0] a;
        input adv;
        begin
            if (adv)
                addr_after = a + `EHP_ADDR_ONE;
            else
                addr_after = a;
        end
    endfunction

    assign CTRL_OUT = ctrl_r;
    assign HOST_READY_OUT = ready_r;
    assign HOST_DATA_OE = oe_r & strobe;

    // Strobe level of the last edge, for start detection
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            strobe_r <= 1'b0;
        end else if (CE) begin
            strobe_r <= strobe;
        end
    end

    // Next state: idle, memory owed, or waiting for strobe release
    always @* begin
        st_nxt = st_r;
        case (st_r)
            `EHP_ST_IDLE: begin
                if (take_mem)
                    st_nxt = `EHP_ST_MEM;
                else if (take)
                    st_nxt = `EHP_ST_DONE;
            end
            `EHP_ST_MEM: begin
                // Latency grows with competing memory traffic
                if (MEM_ACK)
                    st_nxt = `EHP_ST_DONE;
            end
            `EHP_ST_DONE: begin
                if (!strobe)
                    st_nxt = `EHP_ST_IDLE;
            end
            default: st_nxt = `EHP_ST_IDLE;
        endcase
    end

    // State and the kind of access latched at its start
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_r <= `EHP_ST_IDLE;
            cur_sel_r <= `EHP_SEL_CTRL;
        end else if (CE) begin
            st_r <= st_nxt;
            if (take)
                cur_sel_r <= csel;
        end
    end

    // Control register, reached by select code zero
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_r <= `EHP_CTRL_RST;
        end else if (CE) begin
            if (take_ctrl & ~rw)
                ctrl_r <= din;
        end
    end

    // Base and running address; readback shows only the base
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            base_r <= `EHP_ADDR_RST;
            addr_r <= `EHP_ADDR_RST;
        end else if (CE) begin
            if (take_addr & ~rw) begin
                base_r <= din;
                addr_r <= din;
            end else if (mem_done) begin
                addr_r <= addr_after(addr_r, step);
            end
        end
    end

    // Read data stands until the next read
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            HOST_DATA_OUT <= `EHP_DATA_RST;
        end else if (CE) begin
            if (take_ctrl & rw)
                HOST_DATA_OUT <= ctrl_r;
            else if (take_addr & rw)
                HOST_DATA_OUT <= base_r;
            else if (mem_done & ~MEM_WE)
                HOST_DATA_OUT <= MEM_RDATA;
        end
    end

    // Ready low only while memory is owed, never masked
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            ready_r <= 1'b1;
            oe_r <= 1'b0;
        end else if (CE) begin
            if (take_mem)
                ready_r <= 1'b0;
            else if (mem_done)
                ready_r <= 1'b1;
            if (take)
                oe_r <= rw;
            else if ((st_r == `EHP_ST_DONE) & ~strobe)
                oe_r <= 1'b0;
        end
    end

    // Memory request held until the memory answers
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            MEM_REQ <= 1'b0;
            MEM_WE <= 1'b0;
            MEM_ADDR <= `EHP_ADDR_RST;
            MEM_WDATA <= `EHP_DATA_RST;
            MEM_BE <= `EHP_BE_RST;
        end else if (CE) begin
            if (take_mem) begin
                MEM_REQ <= 1'b1;
                MEM_WE <= ~rw;
                MEM_ADDR <= addr_r;
                MEM_WDATA <= din;
                MEM_BE <= ~be_n;
            end else if (mem_done) begin
                MEM_REQ <= 1'b0;
            end
        end
    end
endmodule // ehp_port
`default_nettype wire

// ===== tb/ehp_port_asserts.sv
// Checker of the host port access behaviour
`default_nettype none
module ehp_chk (
    input wire logic CLK, RST, MUX_MODE, HOST_CHIP_SELECT_N, HOST_DATA_STROBE_A, HOST_DATA_STROBE_B,
    input wire logic [1:0] ACCESS_SELECT, HOST_BYTE_ENABLE_N, MEM_BE,
    input wire logic HOST_READY_OUT, MEM_REQ, MEM_ACK
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // Start of a memory cycle
    sequence s_go; $rose(MEM_REQ); endsequence
    property p_sel; s_go |-> MUX_MODE | ACCESS_SELECT[0]; endproperty
    a_sel: assert property (p_sel) else $error("memory hit by control access");
    property p_stb; s_go |-> !(HOST_CHIP_SELECT_N | HOST_DATA_STROBE_A | HOST_DATA_STROBE_B); endproperty
    a_stb: assert property (p_stb) else $error("memory cycle without strobe");
    property p_be; s_go |-> MEM_BE == ~HOST_BYTE_ENABLE_N; endproperty
    a_be: assert property (p_be) else $error("byte enables wrong");
    property p_rlo; MEM_REQ |-> !HOST_READY_OUT; endproperty
    a_rlo: assert property (p_rlo) else $error("ready high during request");
    property p_rup; MEM_REQ && MEM_ACK |=> HOST_READY_OUT; endproperty
    a_rup: assert property (p_rup) else $error("ready not back after ack");
    property p_hold; MEM_REQ && !MEM_ACK |=> MEM_REQ; endproperty
    a_hold: assert property (p_hold) else $error("request dropped early");
endmodule // ehp_chk
bind ehp_port ehp_chk u_chk (.*);
`default_nettype wire

// ===== tb/ehp_mem_model.sv
// Memory behind the host port, answering after a set delay
`default_nettype none
module ehp_mem_model (
    input wire logic clk, req, we,
    input wire logic [15:0] addr, wdata,
    input wire logic [1:0] be,
    input wire logic [3:0] dly,
    output logic ack = 1'b0,
    output logic [15:0] rdata = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] m [logic [15:0]];
    int n = 0;
    // Slow answer stands for competing traffic; data toggles off ack
    always @(posedge clk) begin
        ack <= 1'b0;
        rdata <= ~rdata;
        if (req && !ack && n < dly) n <= n + 1;
        else if (req && !ack) begin
            n <= 0;
            ack <= 1'b1;
            if (!m.exists(addr)) m[addr] = 16'h0000;
            if (we && be[0]) m[addr][7:0] = wdata[7:0];
            if (we && be[1]) m[addr][15:8] = wdata[15:8];
            rdata <= m[addr];
        end
    end
endmodule // ehp_mem_model
`default_nettype wire

// ===== tb/tb_top.sv
// Testbench for the host port access block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 0, RST = 1, mux = 1, cs_n = 1, ds = 1, rw = 0, cs_str = 0, rdy, req, we, ack, oe, got_oe;
    logic [1:0] sel = 0, be_n = 0, mbe;
    logic [3:0] dly = 4'h1;
    logic [15:0] din = 0, dout, ctrl, addr, wd, rd, got;
    int n_fail = 0, n_compared = 0;
    always #2 CLK = ~CLK;
    ehp_port u_ehp_port (.CLK(CLK), .RST(RST), .CE(1'b1), .MUX_MODE(mux), .HOST_CHIP_SELECT_N(cs_n),
        .HOST_DATA_STROBE_A(ds), .HOST_DATA_STROBE_B(ds), .HOST_RW(rw), .ACCESS_SELECT(sel),
        .HOST_BYTE_ENABLE_N(be_n), .HOST_DATA_IN(din), .HOST_DATA_OUT(dout), .HOST_DATA_OE(oe),
        .HOST_READY_OUT(rdy), .CTRL_OUT(ctrl), .MEM_REQ(req), .MEM_WE(we), .MEM_ADDR(addr),
        .MEM_WDATA(wd), .MEM_BE(mbe), .MEM_ACK(ack), .MEM_RDATA(rd));
    ehp_mem_model u_ehp_mem_model (.clk(CLK), .req(req), .we(we), .addr(addr), .wdata(wd), .be(mbe),
        .dly(dly), .ack(ack), .rdata(rd));
    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // One host access; select held for the whole access
    task automatic acc(logic [1:0] s, logic r, logic [1:0] b, logic [15:0] d);
        @(negedge CLK);
        {sel, rw, be_n, din} = {s, r, b, d};
        cs_n = 1'b0;
        @(negedge CLK);
        ds = 1'b0;
        repeat (4) @(negedge CLK);
        for (int i = 0; i < 40 && rdy !== 1'b1; i++) @(negedge CLK);
        got = dout;
        got_oe = oe;
        ds = !cs_str;
        @(negedge CLK);
        cs_n = 1'b1;
        repeat (4) @(negedge CLK);
    endtask
    task automatic t_ctrl;
        mux = 0;
        acc(2'h0, 0, 2'h0, 16'h00A5);
        mux = 1;
        chk("ctrl", ctrl, 16'h00A5);
        chk("oe on write", {15'h0000, got_oe}, 16'h0000);
    endtask
    task automatic t_auto;
        acc(2'h2, 0, 2'h0, 16'h0010);
        acc(2'h1, 0, 2'h0, 16'h1111);
        acc(2'h1, 0, 2'h0, 16'h2222);
        acc(2'h2, 1, 2'h0, 16'h0000);
        chk("base", got, 16'h0010);
        acc(2'h2, 0, 2'h0, 16'h0010);
        acc(2'h1, 1, 2'h0, 16'h0000);
        chk("first", got, 16'h1111);
        chk("oe on read", {15'h0000, got_oe}, 16'h0001);
        acc(2'h1, 1, 2'h0, 16'h0000);
        chk("next", got, 16'h2222);
    endtask
    task automatic t_byte;
        acc(2'h2, 0, 2'h0, 16'h0020);
        acc(2'h1, 0, 2'h2, 16'h00AB);
        acc(2'h1, 0, 2'h1, 16'hCD00);
        acc(2'h2, 0, 2'h0, 16'h0020);
        acc(2'h3, 1, 2'h0, 16'h0000);
        chk("bytes", got, 16'hCDAB);
    endtask
    // Chip select as strobe, slow memory
    task automatic t_cs;
        acc(2'h2, 0, 2'h0, 16'h0030);
        {dly, cs_str, ds, mux} = 7'h4C;
        acc(2'h1, 0, 2'h0, 16'h5A5A);
        acc(2'h1, 1, 2'h0, 16'h0000);
        chk("cs strobe", got, 16'h5A5A);
    endtask
    task report_and_stop;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge CLK);
        RST = 0;
        t_ctrl;
        t_auto;
        t_byte;
        t_cs;
        report_and_stop;
    end
    // Watchdog well past the expected run
    initial begin
        #20000;
        n_fail++;
        report_and_stop;
    end
endmodule // tb_top
`default_nettype wire
